// [hw/gpio_port_pkg.sv]
// Purpose: constants for the 32-pin port control block
// Assumes: 32-bit AXI4-Lite register bus, byte offsets as printed
// Notes: every config register has rw/set/clear/toggle aliases
// Contract
// - every register holds one bit per pin, bit n for pin n
// - config registers answer at four words: write, set, clear, toggle
// - three select bits form code 000 for function A to 111 for H
// - driver enable one turns the pin driver on, zero keeps it off
// - pin is driven with the output value bit level
// - pin level register at 0x060 returns present pin levels
// - pin level valid only under port control or with interrupt enabled
// - pull pair: 00 none, 01 down, 10 up, 11 buskeeper
// - interrupt enable one allows detection, zero disables it
// - mode 00 any change, 01 rising, 10 falling, 11 reserved
// - glitch filter enable filters input before edge detection
// - filter change with interrupt enabled may give spurious interrupt
// - flag set on condition, read at 0x0D0, cleared at 0x0D8
// - flags meaningful only where interrupt enable is one
// - port enable zero gives pin to peripheral, one to port
// - registers reset to zero except listed instance values
package gpio_port_pkg;
	localparam int unsigned pin_count = 32;
	localparam logic [8:0] off_port_enable = 9'h000;
	localparam logic [8:0] off_func_sel0 = 9'h010;
	localparam logic [8:0] off_func_sel1 = 9'h020;
	localparam logic [8:0] off_func_sel2 = 9'h030;
	localparam logic [8:0] off_drv_enable = 9'h040;
	localparam logic [8:0] off_out_value = 9'h050;
	localparam logic [8:0] off_pin_level = 9'h060;
	localparam logic [8:0] off_pullup = 9'h070;
	localparam logic [8:0] off_pulldown = 9'h080;
	localparam logic [8:0] off_irq_enable = 9'h090;
	localparam logic [8:0] off_irq_mode0 = 9'h0a0;
	localparam logic [8:0] off_irq_mode1 = 9'h0b0;
	localparam logic [8:0] off_glitch = 9'h0c0;
	localparam logic [8:0] off_irq_flags = 9'h0d0;
	localparam logic [8:0] off_irq_flags_clr = 9'h0d8;
	localparam int unsigned cfg_count = 12;
	// alias selector in address bits 3:2
	localparam logic [1:0] alias_write = 2'h0;
	localparam logic [1:0] alias_set = 2'h1;
	localparam logic [1:0] alias_clear = 2'h2;
	localparam logic [1:0] alias_toggle = 2'h3;
	// reset values
	localparam logic [31:0] rst_port_enable = 32'hffff_ffff;
	localparam logic [31:0] rst_zero = 32'h0000_0000;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	localparam logic [1:0] mode_change = 2'h0;
	localparam logic [1:0] mode_rise = 2'h1;
	localparam logic [1:0] mode_fall = 2'h2;
endpackage

// [hw/gpio_port_pin_control.sv]
// Purpose: register control for one 32-pin general purpose port
// Assumes: AXI4-Lite slave, one write and one read in flight
// Notes: all outputs registered; pin inputs synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_control
	import gpio_port_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [8:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read
	input wire logic [8:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic [31:0] pin_in,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe,
	output logic [31:0] pin_pullup,
	output logic [31:0] pin_pulldown,
	// peripheral side
	input wire logic [31:0] periph_out [8],
	input wire logic [31:0] periph_oe [8],
	output logic [31:0] periph_in,
	output logic [31:0] func_sel [3],
	// interrupt
	output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// register store: index 0 port enable, 1..3 select, 4 drive, 5 value,
// 6 pullup, 7 pulldown, 8 irq enable, 9..10 mode, 11 glitch
logic [31:0] cfg [cfg_count];
logic [31:0] flags;
logic [8:0] aw_addr;
logic aw_held;
logic [31:0] w_data;
logic [3:0] w_strb;
logic w_held;
logic [31:0] sync_a;
logic [31:0] sync_b;
logic [31:0] filt_prev;
logic [31:0] filt_level;
logic [31:0] det_prev;

// write happens once both halves are held and no response pending
wire do_write = aw_held && w_held && !s_axi_bvalid;
// address slots skip the read-only pin level word, so later slots shift down one
wire [4:0] w_slot = aw_addr[8:4];
wire [3:0] w_index = (w_slot > off_pin_level[8:4]) ? 4'(w_slot - 5'd1) : 4'(w_slot);
wire [1:0] w_alias = aw_addr[3:2];
wire w_cfg_hit = (w_slot <= off_glitch[8:4]) && (w_slot != off_pin_level[8:4]);
wire w_clr_hit = (aw_addr == off_irq_flags_clr);
wire w_ok = w_cfg_hit || w_clr_hit;
wire [31:0] w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
wire [31:0] w_bits = w_data & w_mask;

////////////////////////////////////////////////////////////////////////////////
// axi write channels, address and data accepted in either order
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 9'h000;
		w_data <= rst_zero;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= resp_okay;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= w_ok ? resp_okay : resp_slverr;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ready only while that half is empty; no skid buffer by design
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
	end
	else
	begin
		s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !do_write;
		s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !do_write;
	end
end

////////////////////////////////////////////////////////////////////////////////
// config registers, one generate entry each
genvar gi;
generate
	for (gi = 0; gi < cfg_count; gi++)
	begin : g_cfg
		// reset to zero except port enable
		localparam logic [31:0] rst_val = (gi == 0) ? rst_port_enable : rst_zero;
		wire hit = do_write && w_cfg_hit && (w_index == 4'(gi));
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cfg[gi] <= rst_val;
			else if (hit)
			begin
				unique case (w_alias)
					alias_write: cfg[gi] <= (cfg[gi] & ~w_mask) | w_bits;
					alias_set: cfg[gi] <= cfg[gi] | w_bits;
					alias_clear: cfg[gi] <= cfg[gi] & ~w_bits;
					alias_toggle: cfg[gi] <= cfg[gi] ^ w_bits;
				endcase
			end
		end
	end
endgenerate

wire [31:0] port_en = cfg[0];
wire [31:0] irq_en = cfg[8];
wire [31:0] mode0 = cfg[9];
wire [31:0] mode1 = cfg[10];
wire [31:0] glitch_en = cfg[11];
// filter chosen per pin; switching it may fake an edge
wire [31:0] det_in = (glitch_en & filt_level) | (~glitch_en & sync_b);

////////////////////////////////////////////////////////////////////////////////
// input sampling, two-stage filter and edge detect
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		sync_a <= rst_zero;
		sync_b <= rst_zero;
		filt_prev <= rst_zero;
		filt_level <= rst_zero;
		det_prev <= rst_zero;
	end
	else
	begin
		sync_a <= pin_in;
		sync_b <= sync_a;
		filt_prev <= sync_b;
		// level passes after two equal samples
		filt_level <= (sync_b & filt_prev) | (filt_level & (sync_b | filt_prev));
		det_prev <= det_in;
	end
end

wire [31:0] rise = det_in & ~det_prev;
wire [31:0] fall = ~det_in & det_prev;
// mode select; code 11 detects nothing
wire [31:0] cond = (~mode1 & ~mode0 & (rise | fall)) | (~mode1 & mode0 & rise)
	| (mode1 & ~mode0 & fall);
wire [31:0] hit_ev = cond & irq_en;
wire [31:0] clr_bits = (do_write && w_clr_hit) ? w_bits : rst_zero;

////////////////////////////////////////////////////////////////////////////////
// sticky flags, new event wins over clear
always_ff @(posedge aclk)
begin
	if (!aresetn)
		flags <= rst_zero;
	else
		flags <= (flags & ~clr_bits) | hit_ev;
end

////////////////////////////////////////////////////////////////////////////////
// read channel
// same slot shift as the write side; aliases read back as errors
wire [4:0] r_slot = s_axi_araddr[8:4];
wire [3:0] r_index = (r_slot > off_pin_level[8:4]) ? 4'(r_slot - 5'd1) : 4'(r_slot);
wire r_cfg_hit = (r_slot <= off_glitch[8:4]) && (r_slot != off_pin_level[8:4])
	&& (s_axi_araddr[3:2] == alias_write);
wire r_lvl_hit = (s_axi_araddr == off_pin_level);
wire r_flag_hit = (s_axi_araddr == off_irq_flags);
wire [31:0] r_cfg_val = cfg[r_index];
wire [31:0] next_rdata = r_cfg_hit ? r_cfg_val : r_lvl_hit ? sync_b
	: r_flag_hit ? flags : rst_zero;
wire r_ok = r_cfg_hit || r_lvl_hit || r_flag_hit;

always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= rst_zero;
		s_axi_rresp <= resp_okay;
	end
	else
	begin
		s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= r_ok ? resp_okay : resp_slverr;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin muxing, per pin
// bit n drives pin n
generate
	for (gi = 0; gi < pin_count; gi++)
	begin : g_pin
		wire [2:0] code = {cfg[3][gi], cfg[2][gi], cfg[1][gi]};
		// port or peripheral owns the pin
		wire next_oe = port_en[gi] ? cfg[4][gi] : periph_oe[code][gi];
		wire next_out = port_en[gi] ? cfg[5][gi] : periph_out[code][gi];
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				pin_oe[gi] <= 1'b0;
				pin_out[gi] <= 1'b0;
			end
			else
			begin
				pin_oe[gi] <= next_oe;
				pin_out[gi] <= next_out;
			end
		end
	end
endgenerate

// pull pair passed to the pad; both set means buskeeper
always_ff @(posedge aclk)
begin
	if (!aresetn)
	begin
		pin_pullup <= rst_zero;
		pin_pulldown <= rst_zero;
		periph_in <= rst_zero;
		func_sel[0] <= rst_zero;
		func_sel[1] <= rst_zero;
		func_sel[2] <= rst_zero;
		irq <= 1'b0;
	end
	else
	begin
		pin_pullup <= cfg[6];
		pin_pulldown <= cfg[7];
		periph_in <= sync_b;
		func_sel[0] <= cfg[1];
		func_sel[1] <= cfg[2];
		func_sel[2] <= cfg[3];
		irq <= |(flags & irq_en);
	end
end

////////////////////////////////////////////////////////////////////////////////
// checks
property p_flag_set;
	@(posedge aclk) disable iff (!aresetn)
		(hit_ev != 0) |=> ((flags & $past(hit_ev)) == $past(hit_ev));
endproperty
a_flag_set: assert property (p_flag_set) else $error("flag not set on event");

property p_irq;
	@(posedge aclk) disable iff (!aresetn) |(flags & irq_en) |=> irq;
endproperty
a_irq: assert property (p_irq) else $error("irq missing");

property p_irq_off;
	@(posedge aclk) disable iff (!aresetn) ((flags & irq_en) == 0) |=> !irq;
endproperty
a_irq_off: assert property (p_irq_off) else $error("irq without enabled flag");

// a flag that was not up may only rise on a pin whose enable was on
property p_no_ev_disabled;
	@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> ((flags & ~$past(flags) & ~$past(irq_en)) == 0);
endproperty
a_no_ev_disabled: assert property (p_no_ev_disabled) else $error("flag while off");

property p_reserved;
	@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> ((flags & ~$past(flags) & $past(mode1) & $past(mode0)) == 0);
endproperty
a_reserved: assert property (p_reserved) else $error("reserved mode fired");

property p_port_drive;
	@(posedge aclk) disable iff (!aresetn) port_en[0] |=> (pin_oe[0] == $past(cfg[4][0]));
endproperty
a_port_drive: assert property (p_port_drive) else $error("driver enable mismatch");

property p_port_value;
	@(posedge aclk) disable iff (!aresetn) port_en[0] |=> (pin_out[0] == $past(cfg[5][0]));
endproperty
a_port_value: assert property (p_port_value) else $error("output value mismatch");

property p_filter;
	@(posedge aclk) disable iff (!aresetn)
		(sync_b == filt_prev) |=> (filt_level == $past(sync_b));
endproperty
a_filter: assert property (p_filter) else $error("filter did not settle");

property p_bresp;
	@(posedge aclk) disable iff (!aresetn) do_write |=> s_axi_bvalid;
endproperty
a_bresp: assert property (p_bresp) else $error("write response missing");

endmodule // gpio_port_pin_control
`default_nettype wire

// [dv/gpio_port_far_side.sv]
// Purpose: model of the pads and the peripherals around the port
// Assumes: the bench sets the level that an outside circuit forces
// Notes: an undriven pin with both pulls follows the outside level
`timescale 1ns/10ps
`default_nettype none
module gpio_port_far_side
(
	// pad side
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_pullup,
	input wire logic [31:0] pin_pulldown,
	input wire logic [31:0] ext_level,
	output logic [31:0] pin_in,
	// peripherals
	output logic [31:0] periph_out [8],
	output logic [31:0] periph_oe [8]
);
	// own driver wins, then a lone pull, else the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup & ~pin_pulldown)
		| (~pin_oe & ~(pin_pullup ^ pin_pulldown) & ext_level);
	// function k marks bit k of each byte, so a wrong code reads as zero
	for (genvar k = 0; k < 8; k++)
	begin : g_fn
		assign periph_out[k] = {4{8'h01 << k}};
		assign periph_oe[k] = {4{8'h01 << k}};
	end
endmodule // gpio_port_far_side
`default_nettype wire

// [dv/gpio_port_pin_control_bench.sv]
// Purpose: register-level tests of the port control block
// Assumes: registered slave outputs, pin path a few cycles late
// Notes: sequences of bus calls with expected values
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_control_bench import gpio_port_pkg::*; ();
	logic aclk;
	logic aresetn;
	logic [8:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, pin_out, pin_oe, periph_in, ext_level;
	logic [31:0] pin_pullup, pin_pulldown;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] periph_out [8];
	logic [31:0] periph_oe [8];
	logic [31:0] func_sel [3];
	logic [3:0] rise_tab = 4'b0011;
	logic [3:0] fall_tab = 4'b0101;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	gpio_port_pin_control i_dut (.*);
	gpio_port_far_side i_far (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.pin_pulldown(pin_pulldown), .ext_level(ext_level), .pin_in(pin_in),
		.periph_out(periph_out), .periph_oe(periph_oe));
	////////////////////////////////////////////////////////////////
	// clock, and a ceiling well above the whole sequence
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// one idle edge first, so no strobe is assigned twice in a time step
	task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] e = resp_okay);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'(e));
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] x, input logic [1:0] e = resp_okay);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, x);
		chk("rresp", 32'(s_axi_rresp), 32'(e));
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 9'h000;
		s_axi_araddr = 9'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		ext_level = 32'h0000_0000;
		step(2);
		aresetn <= 1'b1;
		step(2);
		rd(off_port_enable, rst_port_enable);
		rd(off_out_value, rst_zero);
		rd(off_irq_flags, rst_zero);
		rd(9'h1f8, rst_zero, resp_slverr);
		rd(off_out_value + 9'h004, rst_zero, resp_slverr);
		wr(off_pin_level, 32'hffff_ffff, resp_slverr);
		wr(off_irq_flags, 32'hffff_ffff, resp_slverr);
		// every mode against a rising then a falling edge on pin 0
		for (int m = 0; m < 4; m++)
		begin
			wr(off_irq_enable, rst_zero);
			wr(off_irq_mode0, 32'(m % 2));
			wr(off_irq_mode1, 32'(m / 2));
			wr(off_irq_flags_clr, 32'hffff_ffff);
			wr(off_irq_enable, 32'h0000_0001);
			ext_level <= 32'h0000_0001;
			step(8);
			rd(off_irq_flags, 32'(rise_tab[m]));
			chk("irq", 32'(irq), 32'(rise_tab[m]));
			wr(off_irq_flags_clr, 32'hffff_ffff);
			ext_level <= 32'h0000_0000;
			step(8);
			rd(off_irq_flags, 32'(fall_tab[m]));
		end
		// a rising edge on pin 0 while its interrupt is disabled
		wr(off_irq_enable, rst_zero);
		wr(off_irq_mode1, rst_zero);
		ext_level <= 32'h0000_0001;
		step(8);
		// an edge seen while disabled must not surface once enabled
		wr(off_irq_enable, 32'h0000_0001);
		step(2);
		chk("irq", 32'(irq), 32'h0000_0000);
		wr(off_irq_enable, rst_zero);
		// filter turned on only while the pin interrupt is off
		ext_level <= 32'h0000_0000;
		wr(off_glitch, 32'h0000_0001);
		wr(off_irq_flags_clr, 32'hffff_ffff);
		wr(off_irq_enable, 32'h0000_0001);
		ext_level <= 32'h0000_0001;
		step(1);
		ext_level <= 32'h0000_0000;
		step(8);
		rd(off_irq_flags, rst_zero);
		ext_level <= 32'h0000_0001;
		step(8);
		rd(off_irq_flags, 32'h0000_0001);
		// pin levels, then pulls changing what the pads settle to
		ext_level <= 32'h1234_5678;
		step(4);
		rd(off_pin_level, 32'h1234_5678);
		chk("periph_in", periph_in, 32'h1234_5678);
		wr(off_pullup, 32'h0000_0003);
		wr(off_pulldown + 9'h004, 32'h0000_0005);
		step(4);
		chk("pull", {pin_pullup[15:0], pin_pulldown[15:0]}, 32'h0003_0005);
		rd(off_pin_level, 32'h1234_567a);
		// set, clear and toggle touch only bits written as one
		wr(off_out_value, 32'h0000_00f0);
		wr(off_out_value + 9'h004, 32'h0000_000f);
		wr(off_out_value + 9'h008, 32'h0000_0011);
		wr(off_out_value + 9'h00c, 32'h0000_0101);
		rd(off_out_value, 32'h0000_01ef);
		wr(off_drv_enable, 32'hffff_ffff);
		step(2);
		chk("pin_out", pin_out, 32'h0000_01ef);
		chk("pin_oe", pin_oe, 32'hffff_ffff);
		rd(off_pin_level, 32'h0000_01ef);
		// pins 0..7 handed to function k = pin number
		wr(off_func_sel0, 32'h0000_00aa);
		wr(off_func_sel1, 32'h0000_00cc);
		wr(off_func_sel2, 32'h0000_00f0);
		wr(off_port_enable + 9'h008, 32'h0000_00ff);
		step(2);
		chk("periph", {pin_oe[15:0], pin_out[15:0]}, 32'hffff_01ff);
		chk("sel2", func_sel[2], 32'h0000_00f0);
		rd(off_port_enable, 32'hffff_ff00);
		print_verdict();
	end
endmodule // gpio_port_pin_control_bench
`default_nettype wire
